// [rtl/fbar_pkg.sv]
// Shared constants for the fieldbus acyclic register access link.
package fbar_pkg;
    localparam int FBAR_SLOT_W = 4;
    localparam int FBAR_INDEX_W = 12;
    localparam int FBAR_LEN_W = 3;
    localparam logic [FBAR_SLOT_W-1:0] FBAR_SLOT_MIN = 4'h1;
    localparam logic [FBAR_SLOT_W-1:0] FBAR_SLOT_MAX = 4'hc;
    localparam logic [FBAR_SLOT_W-1:0] FBAR_CYC_SLOTS = 4'h4;
    localparam logic [FBAR_INDEX_W-1:0] FBAR_VARIANT_MUL = 12'h0ff;
    localparam logic [15:0] FBAR_REG_REMOTE = 16'h0192;
    localparam logic [15:0] FBAR_REG_ISET = 16'h01f5;
    localparam logic [15:0] FBAR_REG_STATUS = 16'h01f9;
    localparam logic [15:0] FBAR_REG_VOLT = 16'h01fb;
    localparam logic [15:0] FBAR_REG_CURR = 16'h01fc;
    localparam logic [15:0] FBAR_REG_POWER = 16'h01fd;
    localparam logic [FBAR_SLOT_W-1:0] FBAR_SLOT_REMOTE = 4'h2;
    localparam logic [FBAR_INDEX_W-1:0] FBAR_IDX_REMOTE = 12'h001;
    localparam logic [FBAR_SLOT_W-1:0] FBAR_SLOT_ISET = 4'h2;
    localparam logic [FBAR_INDEX_W-1:0] FBAR_IDX_ISET = 12'h018;
    localparam logic [FBAR_SLOT_W-1:0] FBAR_SLOT_STATUS = 4'h1;
    localparam logic [FBAR_INDEX_W-1:0] FBAR_IDX_STATUS = 12'h001;
    localparam logic [FBAR_SLOT_W-1:0] FBAR_SLOT_VOLT = 4'h2;
    localparam logic [FBAR_INDEX_W-1:0] FBAR_IDX_VOLT = 12'h01c;
    localparam logic [FBAR_INDEX_W-1:0] FBAR_IDX_CURR = 12'h01d;
    localparam logic [FBAR_INDEX_W-1:0] FBAR_IDX_POWER = 12'h01e;
    localparam logic [15:0] FBAR_REMOTE_ON = 16'hff00;
    localparam logic [15:0] FBAR_REMOTE_OFF = 16'h0000;
    localparam logic [15:0] FBAR_PCT_MAX = 16'hcccc;
    localparam logic [FBAR_LEN_W-1:0] FBAR_LEN_WORD = 3'h2;
    localparam logic [FBAR_LEN_W-1:0] FBAR_LEN_VI = 3'h4;
    localparam logic [FBAR_LEN_W-1:0] FBAR_LEN_VIP = 3'h6;
    localparam int FBAR_ST_MASTER = 6;
    localparam int FBAR_ST_OUTON = 7;
    localparam int FBAR_ST_CCREG = 10;
    localparam int FBAR_ST_SINK = 12;
    localparam int FBAR_ST_REMOTE = 11;
    localparam logic [1:0] FBAR_RSP_OK = 2'h0;
    localparam logic [1:0] FBAR_RSP_NOIDX = 2'h1;
    localparam logic [1:0] FBAR_RSP_DENIED = 2'h2;
    localparam logic [1:0] FBAR_RSP_RANGE = 2'h3;
    localparam logic [7:0] FBAR_CMD_ADDR = 8'h00;
    localparam logic [7:0] FBAR_IDXR_ADDR = 8'h01;
    localparam logic [7:0] FBAR_WDATA_ADDR = 8'h02;
    localparam logic [7:0] FBAR_STAT_ADDR = 8'h03;
    localparam logic [7:0] FBAR_RD0_ADDR = 8'h04;
    localparam logic [7:0] FBAR_RD1_ADDR = 8'h05;
    localparam logic [7:0] FBAR_RD2_ADDR = 8'h06;
    localparam logic [7:0] FBAR_CYC_ADDR = 8'h07;
    localparam int FBAR_CMD_GO = 0;
    localparam int FBAR_CMD_WR = 1;
    localparam int FBAR_CMD_VAR = 2;
endpackage

// [rtl/fbar_link_if.sv]
// Link between the fieldbus master end and the device end.
`timescale 1ns/1ps
interface fbar_link_if;
    import fbar_pkg::*;
    logic req;
    logic req_write;
    logic [FBAR_SLOT_W-1:0] req_slot;
    logic [FBAR_INDEX_W-1:0] req_index;
    logic [FBAR_LEN_W-1:0] req_len;
    logic [15:0] req_wdata;
    logic rsp;
    logic [1:0] rsp_code;
    logic [47:0] rsp_rdata;
    logic [79:0] cyc_data;
    modport master (output req, output req_write, output req_slot,
        output req_index, output req_len, output req_wdata,
        input rsp, input rsp_code, input rsp_rdata, input cyc_data);
    modport device (input req, input req_write, input req_slot,
        input req_index, input req_len, input req_wdata,
        output rsp, output rsp_code, output rsp_rdata, output cyc_data);
endinterface

// [rtl/fbar_device.sv]
// Device end: acyclic register access decode, remote gating and cyclic data.
`timescale 1ns/1ps
// Summary of operation
// - Accesses address slot one to twelve plus index.
// - Unmapped slot and index is answered unsupported.
// - Master maps index per fieldbus variant.
// - 0xff00 requests remote, 0x0000 returns manual.
// - Remote may be refused; off after reset.
// - Set commands accepted only while remote.
// - Reads always answered, next cycle.
// - Set values are percent codes up to 0xcccc.
// - Four byte read returns voltage then current.
// - Six byte read adds power word.
// - Cyclic slots one to four carry status and actuals.
// - Status bits 6, 7, 10: master, output, constant current.
// - Status bit 12 shows sink mode.
// - Master inverts sink current and power itself.
// - Master verifies writes by reading back.
module fbar_device
    import fbar_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    fbar_link_if.device link,
    input wire logic remote_allowed,
    input wire logic master_cfg,
    input wire logic output_on,
    input wire logic cc_regulation,
    input wire logic sink_mode,
    input wire logic [15:0] volt_meas,
    input wire logic [15:0] curr_meas,
    input wire logic [15:0] power_meas,
    output logic remote_active,
    output logic [15:0] current_setpoint
);
    logic remote_r;
    logic [15:0] iset_r;
    logic rsp_r;
    logic [1:0] code_r;
    logic [47:0] rdata_r;
    logic [79:0] cyc_r;
    logic [31:0] status_w;
    logic slot_ok;
    logic hit_remote;
    logic hit_iset;
    logic hit_status;
    logic hit_volt;
    logic hit_curr;
    logic hit_power;
    logic rd_ok;
    logic wr_ok;
    logic [1:0] code_nxt;
    logic [47:0] rdata_nxt;
    logic [FBAR_INDEX_W-1:0] idx_base;
    logic [FBAR_INDEX_W-1:0] idx_eff;

    always_comb begin
        status_w = '0;
        status_w[FBAR_ST_MASTER] = master_cfg;
        status_w[FBAR_ST_OUTON] = output_on;
        status_w[FBAR_ST_CCREG] = cc_regulation;
        status_w[FBAR_ST_REMOTE] = remote_r;
        status_w[FBAR_ST_SINK] = sink_mode;
    end

    // The second variant folds the slot into the index. Mapped indices stay
    // far below the folded base, so both forms decode without ambiguity.
    assign idx_base = FBAR_INDEX_W'(link.req_slot * FBAR_VARIANT_MUL
        + 12'h001);
    assign idx_eff = (link.req_index >= idx_base)
        ? link.req_index - idx_base : link.req_index;

    // Slot range check first, so a stray slot never aliases a mapped index.
    assign slot_ok = (link.req_slot >= FBAR_SLOT_MIN)
        && (link.req_slot <= FBAR_SLOT_MAX);
    assign hit_remote = slot_ok && link.req_slot == FBAR_SLOT_REMOTE
        && idx_eff == FBAR_IDX_REMOTE;
    assign hit_iset = slot_ok && link.req_slot == FBAR_SLOT_ISET
        && idx_eff == FBAR_IDX_ISET;
    assign hit_status = slot_ok && link.req_slot == FBAR_SLOT_STATUS
        && idx_eff == FBAR_IDX_STATUS;
    assign hit_volt = slot_ok && link.req_slot == FBAR_SLOT_VOLT
        && idx_eff == FBAR_IDX_VOLT;
    assign hit_curr = slot_ok && link.req_slot == FBAR_SLOT_VOLT
        && idx_eff == FBAR_IDX_CURR;
    assign hit_power = slot_ok && link.req_slot == FBAR_SLOT_VOLT
        && idx_eff == FBAR_IDX_POWER;

    always_comb begin
        code_nxt = FBAR_RSP_OK;
        rdata_nxt = '0;
        rd_ok = 1'b0;
        wr_ok = 1'b0;
        if (link.req_write) begin
            if (!(hit_remote || hit_iset)) begin
                code_nxt = FBAR_RSP_NOIDX;
            end else if (hit_iset && !remote_r) begin
                code_nxt = FBAR_RSP_DENIED;
            end else if (hit_iset && link.req_wdata > FBAR_PCT_MAX) begin
                code_nxt = FBAR_RSP_RANGE;
            end else if (hit_remote && link.req_wdata != FBAR_REMOTE_ON
                && link.req_wdata != FBAR_REMOTE_OFF) begin
                code_nxt = FBAR_RSP_RANGE;
            end else if (hit_remote && link.req_wdata == FBAR_REMOTE_ON
                && !remote_allowed) begin
                code_nxt = FBAR_RSP_DENIED;
            end else begin
                wr_ok = 1'b1;
            end
        end else begin
            rd_ok = 1'b1;
            if (hit_status) begin
                rdata_nxt[31:0] = status_w;
            end else if (hit_volt && link.req_len == FBAR_LEN_VIP) begin
                rdata_nxt = {volt_meas, curr_meas, power_meas};
            end else if (hit_volt && link.req_len == FBAR_LEN_VI) begin
                rdata_nxt[31:0] = {volt_meas, curr_meas};
            end else if (hit_volt) begin
                rdata_nxt[15:0] = volt_meas;
            end else if (hit_curr) begin
                rdata_nxt[15:0] = curr_meas;
            end else if (hit_power) begin
                rdata_nxt[15:0] = power_meas;
            end else if (hit_remote) begin
                rdata_nxt[15:0] = remote_r ? FBAR_REMOTE_ON : FBAR_REMOTE_OFF;
            end else if (hit_iset) begin
                rdata_nxt[15:0] = iset_r;
            end else begin
                rd_ok = 1'b0;
                code_nxt = FBAR_RSP_NOIDX;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            remote_r <= 1'b0;
        end else if (link.req && wr_ok && hit_remote) begin
            remote_r <= (link.req_wdata == FBAR_REMOTE_ON);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            iset_r <= 16'h0000;
        end else if (link.req && wr_ok && hit_iset) begin
            iset_r <= link.req_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rsp_r <= 1'b0;
            code_r <= FBAR_RSP_OK;
            rdata_r <= '0;
        end else begin
            rsp_r <= link.req;
            if (link.req) begin
                code_r <= code_nxt;
                rdata_r <= rd_ok ? rdata_nxt : 48'h000000000000;
            end
        end
    end

    // The cyclic image holds status and actuals only, reloaded every cycle.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cyc_r <= '0;
        end else begin
            cyc_r <= {status_w, volt_meas, curr_meas, power_meas};
        end
    end

    assign link.rsp = rsp_r;
    assign link.rsp_code = code_r;
    assign link.rsp_rdata = rdata_r;
    assign link.cyc_data = cyc_r;
    assign remote_active = remote_r;
    assign current_setpoint = iset_r;
endmodule

// [rtl/fbar_master.sv]
// Master end: software registers drive acyclic requests over the link.
`timescale 1ns/1ps
module fbar_master
    import fbar_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    fbar_link_if.master link,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    logic req_r;
    logic write_r;
    logic [FBAR_SLOT_W-1:0] slot_r;
    logic [FBAR_INDEX_W-1:0] index_r;
    logic [FBAR_LEN_W-1:0] len_r;
    logic [15:0] wd_r;
    logic variant_r;
    logic busy_r;
    logic done_r;
    logic [1:0] code_r;
    logic [47:0] rbuf_r;
    logic [31:0] rdata_r;
    logic go;
    logic [FBAR_INDEX_W-1:0] idx_wire;

    assign go = wr && addr == FBAR_CMD_ADDR && wdata[FBAR_CMD_GO] && !busy_r;
    // Second variant folds the slot into the index; only the low bits count.
    assign idx_wire = variant_r ? FBAR_INDEX_W'(slot_r * FBAR_VARIANT_MUL
        + 12'h001 + index_r) : index_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            slot_r <= FBAR_SLOT_MIN;
            index_r <= '0;
            len_r <= FBAR_LEN_WORD;
            wd_r <= 16'h0000;
            write_r <= 1'b0;
            variant_r <= 1'b0;
        end else if (wr && !busy_r) begin
            if (addr == FBAR_IDXR_ADDR) begin
                slot_r <= wdata[FBAR_SLOT_W-1:0];
                index_r <= wdata[16 +: FBAR_INDEX_W];
                len_r <= wdata[28 +: FBAR_LEN_W];
            end
            if (addr == FBAR_WDATA_ADDR) begin
                wd_r <= wdata[15:0];
            end
            if (go) begin
                write_r <= wdata[FBAR_CMD_WR];
                variant_r <= wdata[FBAR_CMD_VAR];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            req_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            code_r <= FBAR_RSP_OK;
            rbuf_r <= '0;
        end else begin
            req_r <= go;
            if (go) begin
                busy_r <= 1'b1;
                done_r <= 1'b0;
            end else if (link.rsp && busy_r) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
                code_r <= link.rsp_code;
                rbuf_r <= link.rsp_rdata;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdata_r <= 32'h00000000;
        end else if (rd) begin
            unique case (addr)
                FBAR_IDXR_ADDR: rdata_r <= {1'b0, len_r, index_r,
                    12'h000, slot_r};
                FBAR_WDATA_ADDR: rdata_r <= {16'h0000, wd_r};
                FBAR_STAT_ADDR: rdata_r <= {28'h0000000, code_r,
                    done_r, busy_r};
                FBAR_RD0_ADDR: rdata_r <= {16'h0000, rbuf_r[47:32]};
                FBAR_RD1_ADDR: rdata_r <= rbuf_r[31:0];
                FBAR_RD2_ADDR: rdata_r <= {16'h0000, rbuf_r[15:0]};
                FBAR_CYC_ADDR: rdata_r <= link.cyc_data[79:48];
                default: rdata_r <= 32'h00000000;
            endcase
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    assign link.req = req_r;
    assign link.req_write = write_r;
    assign link.req_slot = slot_r;
    assign link.req_index = idx_wire;
    assign link.req_len = len_r;
    assign link.req_wdata = wd_r;
    assign rdata = rdata_r;
endmodule

// [verification/fbar_link_asserts.sv]
// Concurrent checks on the link between the master and device ends.
`timescale 1ns/1ps
module fbar_link_asserts
    import fbar_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic req,
    input wire logic req_write,
    input wire logic [FBAR_SLOT_W-1:0] req_slot,
    input wire logic [FBAR_INDEX_W-1:0] req_index,
    input wire logic [FBAR_LEN_W-1:0] req_len,
    input wire logic [15:0] req_wdata,
    input wire logic rsp,
    input wire logic [1:0] rsp_code,
    input wire logic [47:0] rsp_rdata,
    input wire logic [79:0] cyc_data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Measurements are held steady by the bench, so cyclic words serve as truth.
    sequence rd_s(logic [3:0] s, logic [11:0] ix, logic [2:0] n);
        req && !req_write && req_slot == s && req_index == ix && req_len == n;
    endsequence
    sequence wr_s(logic [11:0] ix);
        req && req_write && req_slot == 4'h2 && req_index == ix;
    endsequence
    rsp_follows_a: assert property (req |=> rsp)
        else $error("request without answer");
    rsp_cause_a: assert property (rsp |-> $past(req))
        else $error("answer without request");
    slot_range_a: assert property (req |-> req_slot >= FBAR_SLOT_MIN &&
        req_slot <= FBAR_SLOT_MAX) else $error("slot out of range");
    code_hold_a: assert property (!rsp |-> $stable(rsp_code) &&
        $stable(rsp_rdata)) else $error("answer changed between answers");
    err_data_a: assert property (rsp && rsp_code != FBAR_RSP_OK |->
        rsp_rdata == 48'h0) else $error("data on refused access");
    vi_pair_a: assert property (rd_s(FBAR_SLOT_VOLT, FBAR_IDX_VOLT,
        FBAR_LEN_VI) |=> rsp_rdata == {16'h0, cyc_data[47:16]})
        else $error("voltage current pair wrong");
    vip_word_a: assert property (rd_s(FBAR_SLOT_VOLT, FBAR_IDX_VOLT,
        FBAR_LEN_VIP) |=> rsp_rdata == cyc_data[47:0])
        else $error("six byte read wrong");
    status_rd_a: assert property (rd_s(FBAR_SLOT_STATUS,
        FBAR_IDX_STATUS, FBAR_LEN_VI) |=>
        rsp_rdata[31:0] == cyc_data[79:48]) else $error("status read wrong");
    pct_range_a: assert property (wr_s(FBAR_IDX_ISET) &&
        req_wdata > FBAR_PCT_MAX |=> rsp_code != FBAR_RSP_OK)
        else $error("setpoint above full scale taken");
    remote_val_a: assert property (wr_s(FBAR_IDX_REMOTE) &&
        req_wdata != FBAR_REMOTE_ON && req_wdata != FBAR_REMOTE_OFF
        |=> rsp_code == FBAR_RSP_RANGE) else $error("bad remote value taken");
endmodule

// [verification/tb_top.sv]
// Testbench driving both link ends through the master's software port.
`timescale 1ns/1ps
module tb_top;
    import fbar_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic allow = 1'b0;
    logic st_bit = 1'b1;
    logic [15:0] volt = 16'h263a;
    logic [15:0] curr = 16'h0c9b;
    logic [15:0] pwr = 16'h0925;
    logic remote_active;
    logic [15:0] current_setpoint;
    logic [1:0] code;
    logic [47:0] data;
    logic [31:0] r;
    int err_count = 0;
    int checks_done = 0;
    always #5 sys_clk = ~sys_clk;
    fbar_link_if i_fbar_link_if ();
    fbar_master i_fbar_master (.sys_clk(sys_clk), .rst_b(rst_b),
        .link(i_fbar_link_if), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata));
    fbar_device i_fbar_device (.sys_clk(sys_clk), .rst_b(rst_b),
        .link(i_fbar_link_if), .remote_allowed(allow), .master_cfg(st_bit),
        .output_on(st_bit), .cc_regulation(st_bit), .sink_mode(st_bit),
        .volt_meas(volt), .curr_meas(curr), .power_meas(pwr),
        .remote_active(remote_active), .current_setpoint(current_setpoint));
    fbar_link_asserts i_fbar_link_asserts (.sys_clk(sys_clk), .rst_b(rst_b),
        .req(i_fbar_link_if.req), .req_write(i_fbar_link_if.req_write),
        .req_slot(i_fbar_link_if.req_slot),
        .req_index(i_fbar_link_if.req_index),
        .req_len(i_fbar_link_if.req_len),
        .req_wdata(i_fbar_link_if.req_wdata), .rsp(i_fbar_link_if.rsp),
        .rsp_code(i_fbar_link_if.rsp_code),
        .rsp_rdata(i_fbar_link_if.rsp_rdata),
        .cyc_data(i_fbar_link_if.cyc_data));
    task automatic chk(input string what, input logic [47:0] exp,
        input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // One whole access; the fixed wait of three cycles covers the one-cycle answer latency of the link.
    task automatic xfer(input logic [3:0] s, input logic [11:0] ix,
        input logic [2:0] ln, input logic [15:0] wd, input logic w,
        input logic v, input logic [1:0] exp);
        logic [31:0] hi;
        bus_wr(FBAR_IDXR_ADDR, {1'b0, ln, ix, 12'h000, s});
        bus_wr(FBAR_WDATA_ADDR, {16'h0, wd});
        bus_wr(FBAR_CMD_ADDR, {29'h0, v, w, 1'b1});
        repeat (3) @(posedge sys_clk);
        bus_rd(FBAR_STAT_ADDR, r);
        chk("status", {44'h0, exp, 2'h2}, {16'h0, r});
        bus_rd(FBAR_RD0_ADDR, hi);
        bus_rd(FBAR_RD1_ADDR, r);
        data = {hi[15:0], r};
    endtask
    task automatic t_reset();
        chk("remote", 48'h0, {47'h0, remote_active});
        bus_rd(8'h10, r);
        chk("unmapped", 48'h0, {16'h0, r});
    endtask
    task automatic t_refuse();
        xfer(4'h5, 12'h001, 3'h2, 16'h0, 1'b0, 1'b0, FBAR_RSP_NOIDX);
        chk("data", 48'h0, data);
        xfer(4'h2, 12'h7ff, 3'h2, 16'h1, 1'b1, 1'b0, FBAR_RSP_NOIDX);
        xfer(4'h2, FBAR_IDX_ISET, 3'h2, 16'h1234, 1'b1, 1'b0,
            FBAR_RSP_DENIED);
        chk("setpoint", 48'h0, {32'h0, current_setpoint});
        xfer(4'h2, FBAR_IDX_REMOTE, 3'h2, 16'hff00, 1'b1, 1'b0,
            FBAR_RSP_DENIED);
        chk("remote", 48'h0, {47'h0, remote_active});
    endtask
    task automatic t_remote();
        allow <= 1'b1;
        xfer(4'h2, FBAR_IDX_REMOTE, 3'h2, 16'hff00, 1'b1, 1'b1,
            FBAR_RSP_OK);
        chk("remote", 48'h1, {47'h0, remote_active});
        xfer(4'h2, FBAR_IDX_REMOTE, 3'h2, 16'h1234, 1'b1, 1'b0,
            FBAR_RSP_RANGE);
        xfer(4'h2, FBAR_IDX_ISET, 3'h2, 16'hcccc, 1'b1, 1'b0,
            FBAR_RSP_OK);
        xfer(4'h2, FBAR_IDX_ISET, 3'h2, 16'hcccd, 1'b1, 1'b0,
            FBAR_RSP_RANGE);
        chk("setpoint", 48'hcccc, {32'h0, current_setpoint});
        xfer(4'h2, FBAR_IDX_ISET, 3'h2, 16'h0c0c, 1'b1, 1'b1,
            FBAR_RSP_OK);
        xfer(4'h2, FBAR_IDX_ISET, 3'h2, 16'h0, 1'b0, 1'b0, FBAR_RSP_OK);
        chk("readback", 48'h0c0c, data);
        xfer(4'h2, FBAR_IDX_REMOTE, 3'h2, 16'h0, 1'b1, 1'b0, FBAR_RSP_OK);
        chk("remote", 48'h0, {47'h0, remote_active});
    endtask
    task automatic t_reads();
        xfer(4'h2, FBAR_IDX_VOLT, 3'h2, 16'h0, 1'b0, 1'b0, FBAR_RSP_OK);
        chk("volt", {32'h0, volt}, data);
        xfer(4'h2, FBAR_IDX_VOLT, 3'h4, 16'h0, 1'b0, 1'b0, FBAR_RSP_OK);
        chk("pair", {16'h0, volt, curr}, data);
        xfer(4'h2, FBAR_IDX_VOLT, 3'h6, 16'h0, 1'b0, 1'b0, FBAR_RSP_OK);
        chk("triple", {volt, curr, pwr}, data);
        xfer(4'h1, FBAR_IDX_STATUS, 3'h4, 16'h0, 1'b0, 1'b0, FBAR_RSP_OK);
        chk("status", 48'h14c0, data);
        bus_rd(FBAR_CYC_ADDR, r);
        chk("cyclic", 48'h14c0, {16'h0, r});
        chk("cyc_data", {32'h14c0, volt, curr, pwr},
            i_fbar_link_if.cyc_data[47:0]);
    endtask
    task automatic complete_run();
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_refuse();
        t_remote();
        t_reads();
        complete_run();
    end
    // The sequence needs about 240 cycles; the limit of 10000 cycles leaves wide margin.
    initial begin
        #100000;
        err_count++;
        complete_run();
    end
endmodule
